// ===== pic_params.svh
/*
 * constants for the prioritised interrupt controller: register byte offsets,
 * field positions, reset values, vectors and sequencing counts.
 * assumes it is included by bare name, after the pic_pkg package.
 */
`ifndef PIC_PARAMS_SVH
`define PIC_PARAMS_SVH

// register byte offsets on the avalon slave
`define PIC_OFF_EN_HI     5'h00
`define PIC_OFF_EN_LO     5'h04
`define PIC_OFF_REQ_HI    5'h08
`define PIC_OFF_REQ_LO    5'h0C
`define PIC_OFF_EDGE      5'h10
`define PIC_OFF_CTRL      5'h14
`define PIC_OFF_STAT      5'h18

// control register fields
`define PIC_CTRL_WDRS_BIT 0
`define PIC_CTRL_MEN_BIT  2

// status register fields
`define PIC_STAT_REQ_BIT  16
`define PIC_STAT_WIN_LSB  17
`define PIC_STAT_MEN_BIT  21

// source count and source index of the watchdog
`define PIC_NSRC          12
`define PIC_SRC_WDT       9

// edge select codes, two bits per pin
`define PIC_EDGE_FALL     2'h1
`define PIC_EDGE_RISE     2'h2
`define PIC_EDGE_BOTH     2'h3

// vectors
`define PIC_VEC_RESET     16'hFFFE
`define PIC_VEC_EXT0      16'hFFFA
`define PIC_VEC_STEP      16'h0002
`define PIC_VEC_BRK       16'hFFDE

// reset values
`define PIC_RST_BYTE      8'h00
`define PIC_RST_FLAGS     12'h000

// acceptance sequence length in oscillator clocks, one clock each here
`define PIC_ACCEPT_OSC    8
`define PIC_ACCEPT_CYC    (`PIC_ACCEPT_OSC * 1)

`endif

// ===== pic_pkg.sv
/*
 * types shared by the interrupt controller modules.
 * assumes nothing beyond a systemverilog compiler.
 */
package pic_pkg;

    typedef enum logic [1:0] {
        PIC_IDLE,
        PIC_OFFER,
        PIC_BUSY
    } pic_state_t;

    typedef logic [3:0] pic_idx_t;

endpackage : pic_pkg

// ===== pic_edge_det.sv
/*
 * synchronises the four external interrupt pins and reports the selected
 * transitions as one-cycle pulses.
 * assumes pins are asynchronous to clk; select comes from clk logic.
 */
`timescale 1ns/1ps
`include "pic_params.svh"

module pic_edge_det
    import pic_pkg::*;
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // pins and edge choice
    input  wire logic [3:0] pin_in,
    input  wire logic [7:0] edge_sel,
    // detected edges
    output logic      [3:0] edge_o
);

    logic [3:0] meta_r;
    logic [3:0] sync_r;
    logic [3:0] prev_r;
    logic [3:0] edge_r;
    logic [3:0] edge_nxt;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            case (edge_sel[2*i +: 2])
                `PIC_EDGE_FALL: edge_nxt[i] = prev_r[i] & ~sync_r[i];
                `PIC_EDGE_RISE: edge_nxt[i] = ~prev_r[i] & sync_r[i];
                `PIC_EDGE_BOTH: edge_nxt[i] = prev_r[i] ^ sync_r[i];
                default:        edge_nxt[i] = 1'b0;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= 4'h0;
            sync_r <= 4'h0;
            prev_r <= 4'h0;
            edge_r <= 4'h0;
        end else begin
            meta_r <= pin_in;
            sync_r <= meta_r;
            prev_r <= sync_r;
            edge_r <= edge_nxt;
        end
    end

    assign edge_o = edge_r;

endmodule : pic_edge_det

// ===== pic_ctrl.sv
/*
 * prioritised interrupt controller: twelve latched request flags, per-source
 * enables, a master enable, fixed priority and vector hand-off to the core.
 * assumes an avalon-mm master on clk and a core that pulses irq_ack.
 */
// What this block does
// - two enable, two request, edge select, status, master
// - each pin selects falling, rising or both edges
// - pin edges set four flags in high request
// - vectoring to external source clears its edge flag
// - timer match sets its flag and requests
// - conversion done sets its flag and requests
// - watchdog match flag requests only with reset-select zero
// - interval counter overflow sets its flag and requests
// - acceptance needs master enable, source enable, set flag
// - reset and software break bypass all gating
// - disabled source never accepted; master clear blocks all but break
// - fixed priority ext0 highest down to serial lowest
// - acceptance clears master enable, core loads vector
// - all request flags readable and writable by software
// - pending request held until accepted or cleared
// - simultaneous requests served highest priority first
// - acceptance sequence lasts eight oscillator clocks
// - edges latched each cycle, polled the next
`timescale 1ns/1ps
`include "pic_params.svh"

module pic_ctrl
    import pic_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // avalon-mm slave
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // external interrupt pins
    input  wire logic        ext_pin_zero,
    input  wire logic        ext_pin_one,
    input  wire logic        ext_pin_two,
    input  wire logic        ext_pin_three,
    // peripheral events, one-cycle pulses on clk
    input  wire logic [3:0]  timer_match,
    input  wire logic        conversion_done,
    input  wire logic        watchdog_match,
    input  wire logic        interval_overflow,
    input  wire logic        serial_done,
    // processor core
    input  wire logic        software_break,
    input  wire logic        irq_ack,
    input  wire logic        core_ie_set,
    input  wire logic        core_ie_clr,
    output logic             irq_req,
    output logic      [15:0] irq_vector,
    output logic             master_enable
);

    ////////////////////////////////////////////////////////////////////////
    // helpers

    // high request/enable image: bit 7 is priority 1
    function automatic logic [7:0] rev8(input logic [7:0] v);
        logic [7:0] r;
        r = 8'h00;
        for (int i = 0; i < 8; i++) begin
            r[7-i] = v[i];
        end
        return r;
    endfunction : rev8

    function automatic logic [3:0] rev4(input logic [3:0] v);
        return {v[0], v[1], v[2], v[3]};
    endfunction : rev4

    // lowest index wins, index 0 is priority 1
    function automatic pic_idx_t pick(input logic [`PIC_NSRC-1:0] v);
        pic_idx_t r;
        r = 4'h0;
        for (int i = `PIC_NSRC - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = 4'(i);
            end
        end
        return r;
    endfunction : pick

    function automatic logic [15:0] vec_of(input pic_idx_t idx);
        return `PIC_VEC_EXT0 - (16'(idx) * `PIC_VEC_STEP);
    endfunction : vec_of

    ////////////////////////////////////////////////////////////////////////
    // state

    logic [`PIC_NSRC-1:0] flags_r, flags_nxt;
    logic [`PIC_NSRC-1:0] en_r, en_nxt;
    logic [7:0]           edge_sel_r, edge_sel_nxt;
    logic                 men_r, men_nxt;
    logic                 wdrs_r, wdrs_nxt;
    logic                 brk_r, brk_nxt;

    pic_state_t           st_r, st_nxt;
    logic                 req_r, req_nxt;
    logic [15:0]          vec_r, vec_nxt;
    pic_idx_t             win_r, win_nxt;
    logic                 win_brk_r, win_brk_nxt;
    logic [3:0]           cnt_r, cnt_nxt;

    logic                 wait_r, wait_nxt;
    logic [31:0]          rdata_r, rdata_nxt;

    logic [3:0]           ext_edge;
    logic [`PIC_NSRC-1:0] set_ev;
    logic [`PIC_NSRC-1:0] elig;
    logic                 any_elig;
    logic                 wr_go;
    logic                 ack_src;

    ////////////////////////////////////////////////////////////////////////
    // external pin edge detection
    // two synchroniser flops and one detect flop: three cycles of pin latency

    pic_edge_det u_edge (
        .clk      (clk),
        .rst_n    (rst_n),
        .pin_in   ({ext_pin_three, ext_pin_two, ext_pin_one, ext_pin_zero}),
        .edge_sel (edge_sel_r),
        .edge_o   (ext_edge)
    );

    // index order follows priority
    assign set_ev = {serial_done, interval_overflow,
                     watchdog_match, conversion_done,
                     timer_match[3], timer_match[2],
                     ext_edge[3], ext_edge[2],
                     timer_match[1], timer_match[0],
                     ext_edge[1], ext_edge[0]};

    // watchdog flag still latches but cannot request when it resets the cpu
    always_comb begin
        elig = flags_r & en_r;
        elig[`PIC_SRC_WDT] = elig[`PIC_SRC_WDT] & ~wdrs_r;
        if (!men_r) begin
            elig = '0;
        end
    end

    assign any_elig = |elig;
    // a write lands only at the edge that ends the cycle after its wait cycle, so a request
    // held by the master is never applied twice
    assign wr_go    = avs_write & ~wait_r & avs_byteenable[0];
    assign ack_src  = (st_r == PIC_OFFER) & irq_ack & ~win_brk_r;

    ////////////////////////////////////////////////////////////////////////
    // configuration and request flags

    always_comb begin
        flags_nxt    = flags_r;
        en_nxt       = en_r;
        edge_sel_nxt = edge_sel_r;
        men_nxt      = men_r;
        wdrs_nxt     = wdrs_r;
        brk_nxt      = brk_r | software_break;
        if (wr_go) begin
            case (avs_address)
                `PIC_OFF_EN_HI: en_nxt[7:0] = rev8(avs_writedata[7:0]);
                `PIC_OFF_EN_LO: en_nxt[11:8] = rev4(avs_writedata[7:4]);
                `PIC_OFF_REQ_HI: flags_nxt[7:0] = rev8(avs_writedata[7:0]);
                `PIC_OFF_REQ_LO: flags_nxt[11:8] = rev4(avs_writedata[7:4]);
                `PIC_OFF_EDGE: edge_sel_nxt = avs_writedata[7:0];
                `PIC_OFF_CTRL: begin
                    men_nxt  = avs_writedata[`PIC_CTRL_MEN_BIT];
                    wdrs_nxt = avs_writedata[`PIC_CTRL_WDRS_BIT];
                end
                default: ;
            endcase
        end
        if (core_ie_set) begin
            men_nxt = 1'b1;
        end
        // clear after set: a core clear wins a tie
        if (core_ie_clr) begin
            men_nxt = 1'b0;
        end
        if ((st_r == PIC_OFFER) && irq_ack) begin
            men_nxt = 1'b0;
            if (win_brk_r) begin
                brk_nxt = software_break;
            end
        end
        // the index was latched with the offer, so a later higher event
        // cannot steer the clear onto a source the core never took
        if (ack_src) begin
            flags_nxt[win_r] = 1'b0;
        end
        // a new event in the clearing cycle survives
        flags_nxt = flags_nxt | set_ev;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flags_r    <= `PIC_RST_FLAGS;
            en_r       <= `PIC_RST_FLAGS;
            edge_sel_r <= `PIC_RST_BYTE;
            men_r      <= 1'b0;
            wdrs_r     <= 1'b0;
            brk_r      <= 1'b0;
        end else begin
            flags_r    <= flags_nxt;
            en_r       <= en_nxt;
            edge_sel_r <= edge_sel_nxt;
            men_r      <= men_nxt;
            wdrs_r     <= wdrs_nxt;
            brk_r      <= brk_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // offer, acceptance and hold-off sequencing

    always_comb begin
        st_nxt      = st_r;
        req_nxt     = req_r;
        vec_nxt     = vec_r;
        win_nxt     = win_r;
        win_brk_nxt = win_brk_r;
        cnt_nxt     = cnt_r;
        case (st_r)
            PIC_IDLE, PIC_OFFER: begin
                if ((st_r == PIC_OFFER) && irq_ack) begin
                    // core runs its push and vector fetch meanwhile
                    st_nxt  = PIC_BUSY;
                    req_nxt = 1'b0;
                    cnt_nxt = 4'(`PIC_ACCEPT_CYC - 1);
                end else if (any_elig) begin
                    st_nxt      = PIC_OFFER;
                    req_nxt     = 1'b1;
                    win_nxt     = pick(elig);
                    vec_nxt     = vec_of(pick(elig));
                    win_brk_nxt = 1'b0;
                end else if (brk_r) begin
                    // break sits below every maskable source and ignores gating
                    st_nxt      = PIC_OFFER;
                    req_nxt     = 1'b1;
                    vec_nxt     = `PIC_VEC_BRK;
                    win_brk_nxt = 1'b1;
                end else begin
                    st_nxt  = PIC_IDLE;
                    req_nxt = 1'b0;
                end
            end
            // no offer while the core pushes its return state; a request that
            // arrives meanwhile stays latched and is offered afterwards
            PIC_BUSY: begin
                if (cnt_r == 4'h0) begin
                    st_nxt = PIC_IDLE;
                end else begin
                    cnt_nxt = cnt_r - 4'h1;
                end
            end
            default: begin
                st_nxt  = PIC_IDLE;
                req_nxt = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r      <= PIC_IDLE;
            req_r     <= 1'b0;
            vec_r     <= `PIC_VEC_RESET;
            win_r     <= 4'h0;
            win_brk_r <= 1'b0;
            cnt_r     <= 4'h0;
        end else begin
            st_r      <= st_nxt;
            req_r     <= req_nxt;
            vec_r     <= vec_nxt;
            win_r     <= win_nxt;
            win_brk_r <= win_brk_nxt;
            cnt_r     <= cnt_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // avalon-mm slave: one wait cycle, read data registered
    // the decode reads only registered state, so read data never depends on
    // the bus inputs combinationally; the price is one wait per access

    always_comb begin
        wait_nxt  = 1'b1;
        rdata_nxt = rdata_r;
        if ((avs_read || avs_write) && wait_r) begin
            wait_nxt  = 1'b0;
            rdata_nxt = 32'h0000_0000;
            case (avs_address)
                `PIC_OFF_EN_HI:  rdata_nxt[7:0] = rev8(en_r[7:0]);
                `PIC_OFF_EN_LO:  rdata_nxt[7:4] = rev4(en_r[11:8]);
                `PIC_OFF_REQ_HI: rdata_nxt[7:0] = rev8(flags_r[7:0]);
                `PIC_OFF_REQ_LO: rdata_nxt[7:4] = rev4(flags_r[11:8]);
                `PIC_OFF_EDGE:   rdata_nxt[7:0] = edge_sel_r;
                `PIC_OFF_CTRL: begin
                    rdata_nxt[`PIC_CTRL_MEN_BIT]  = men_r;
                    rdata_nxt[`PIC_CTRL_WDRS_BIT] = wdrs_r;
                end
                `PIC_OFF_STAT: begin
                    rdata_nxt[15:0]               = vec_r;
                    rdata_nxt[`PIC_STAT_REQ_BIT]  = req_r;
                    rdata_nxt[`PIC_STAT_WIN_LSB +: 4] = win_r;
                    rdata_nxt[`PIC_STAT_MEN_BIT]  = men_r;
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wait_r  <= 1'b1;
            rdata_r <= 32'h0000_0000;
        end else begin
            wait_r  <= wait_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs, all straight from flops

    assign avs_readdata    = rdata_r;
    assign avs_waitrequest = wait_r;
    assign irq_req         = req_r;
    assign irq_vector      = vec_r;
    assign master_enable   = men_r;

endmodule : pic_ctrl

// ===== pic_ctrl_checker.sv
/* checker for the interrupt controller ports: bus answer, offer gating, hold-off, reset.
   assumes one clock domain and the bind at the foot of this file. */
`timescale 1ns/1ps
`include "pic_params.svh"
module pic_ctrl_checker
    import pic_pkg::*;
(
    // clock and reset
    input wire logic        clk,
    input wire logic        rst_n,
    // avalon slave
    input wire logic [4:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    // core side
    input wire logic        irq_ack,
    input wire logic        core_ie_set,
    input wire logic        core_ie_clr,
    input wire logic        irq_req,
    input wire logic [15:0] irq_vector,
    input wire logic        master_enable
);
////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence bus_req;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence accept;
        irq_req && irq_ack && !core_ie_set;
    endsequence

    reset_clean_a: assert property ($rose(rst_n) |-> !irq_req && !master_enable
        && irq_vector == `PIC_VEC_RESET) else $error("bad state after reset");
    ack_clears_me_a: assert property (accept |=> !master_enable)
        else $error("master enable kept after accept");
    busy_holdoff_a: assert property (accept |=> !irq_req [*8])
        else $error("offer inside acceptance sequence");
    gated_offer_a: assert property ($rose(irq_req) && irq_vector != `PIC_VEC_BRK
        |-> master_enable || $past(master_enable)) else $error("offer without master");
    vector_table_a: assert property (irq_req |-> irq_vector == `PIC_VEC_BRK
        || (irq_vector <= 16'hFFFA && irq_vector >= 16'hFFE4 && !irq_vector[0]))
        else $error("vector outside table");
    bus_answer_a: assert property (bus_req |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("bus answer not one wait");
    unmapped_zero_a: assert property (!avs_waitrequest && avs_read
        |-> avs_readdata[31:22] == 10'h000 && (avs_address <= 5'h18 || avs_readdata == 32'h0))
        else $error("readdata not zero");
    offer_holds_a: assert property (irq_req && !irq_ack && !avs_write && !$past(avs_write)
        && !core_ie_clr && !$past(core_ie_clr) |=> irq_req) else $error("offer lost");
    ie_set_a: assert property (core_ie_set && !core_ie_clr |=> master_enable)
        else $error("master enable not set");
    clr_wins_a: assert property (core_ie_clr && !avs_write |=> !master_enable)
        else $error("master enable not cleared");
endmodule : pic_ctrl_checker

bind pic_ctrl pic_ctrl_checker u_chk (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq_ack(irq_ack), .core_ie_set(core_ie_set),
    .core_ie_clr(core_ie_clr), .irq_req(irq_req), .irq_vector(irq_vector),
    .master_enable(master_enable));

// ===== pic_core_model.sv
/* behavioural processor core: accepts offers after a chosen delay, then returns.
   assumes the controller's irq_req/irq_vector on the same clock. */
`timescale 1ns/1ps
module pic_core_model
    import pic_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // controller side
    input  wire logic        irq_req,
    input  wire logic [15:0] irq_vector,
    output logic             irq_ack,
    output logic             core_ie_set,
    // test control and log
    input  wire logic [3:0]  ack_delay,
    output logic      [15:0] last_vec,
    output logic      [7:0]  n_acks
);
////////////////////////////////////////////////////////////
    logic [3:0] cnt_r;
    logic [3:0] svc_r;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_ack     <= 1'b0;
            core_ie_set <= 1'b0;
            cnt_r       <= 4'h0;
            svc_r       <= 4'h0;
            last_vec    <= 16'h0000;
            n_acks      <= 8'h00;
        end else begin
            irq_ack     <= 1'b0;
            core_ie_set <= 1'b0;
            if (irq_ack && irq_req) begin
                last_vec <= irq_vector;
                n_acks   <= n_acks + 8'h01;
            end
            if (svc_r != 4'h0) begin
                // service clears nothing itself: the accepted flag is already gone
                svc_r       <= svc_r - 4'h1;
                core_ie_set <= (svc_r == 4'h1);
            end else if (irq_req && !irq_ack) begin
                if (cnt_r >= ack_delay) begin
                    irq_ack <= 1'b1;
                    svc_r   <= 4'hC;
                    cnt_r   <= 4'h0;
                end else begin
                    cnt_r <= cnt_r + 4'h1;
                end
            end
        end
    end
endmodule : pic_core_model

// ===== tb_prioritized_interrupt_controller.sv
/* self-checking bench for pic_ctrl through its avalon slave and core model.
   assumes pic_ctrl, pic_core_model and the bound checker are compiled. */
`timescale 1ns/1ps
`include "pic_params.svh"
module tb_prioritized_interrupt_controller
    import pic_pkg::*;
;
    logic clk, rst_n, avs_read, avs_write, avs_waitrequest, conversion_done, watchdog_match;
    logic interval_overflow, serial_done, software_break, core_ie_clr, irq_ack, core_ie_set;
    logic irq_req, master_enable;
    logic [4:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic [3:0]  pins, timer_match, ack_delay, be;
    logic [15:0] irq_vector, last_vec;
    logic [7:0]  n_acks;
    int          miscompares, checked;

    pic_ctrl uut (.clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(be),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .ext_pin_zero(pins[0]), .ext_pin_one(pins[1]), .ext_pin_two(pins[2]),
        .ext_pin_three(pins[3]), .timer_match(timer_match), .conversion_done(conversion_done),
        .watchdog_match(watchdog_match), .interval_overflow(interval_overflow),
        .serial_done(serial_done), .software_break(software_break), .irq_ack(irq_ack),
        .core_ie_set(core_ie_set), .core_ie_clr(core_ie_clr), .irq_req(irq_req),
        .irq_vector(irq_vector), .master_enable(master_enable));
    pic_core_model u_core (.clk(clk), .rst_n(rst_n), .irq_req(irq_req),
        .irq_vector(irq_vector), .irq_ack(irq_ack), .core_ie_set(core_ie_set),
        .ack_delay(ack_delay), .last_vec(last_vec), .n_acks(n_acks));
////////////////////////////////////////////////////////////
    always #50 clk = ~clk;

    task automatic give_verdict;
        $display("checks %0d, mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : give_verdict

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : chk

    // waits on waitrequest itself; only the bound ends a stuck access
    task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk);
        avs_address   <= a;
        avs_read      <= !wr;
        avs_write     <= wr;
        avs_writedata <= {24'h0, d};
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        rd = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        if (n >= 20) chk(32'h1, 32'h0);
    endtask : bus

    task automatic rdchk(input logic [4:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        chk(rd, {24'h0, e});
    endtask : rdchk

    // bit order: timer_match[3:0], done, watchdog, interval, serial
    task automatic ev(input logic [7:0] m);
        @(posedge clk);
        {timer_match, conversion_done, watchdog_match, interval_overflow, serial_done} <= m;
        @(posedge clk);
        {timer_match, conversion_done, watchdog_match, interval_overflow, serial_done} <= 8'h00;
    endtask : ev

    task automatic wait_acks(input logic [7:0] k, input logic [15:0] v);
        int n;
        n = 0;
        while (n_acks !== k && n < 100) begin
            @(negedge clk);
            n++;
        end
        chk({n_acks, last_vec}, {k, v});
    endtask : wait_acks

    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        give_verdict();
    end

    initial begin
        {clk, rst_n, avs_read, avs_write, software_break, core_ie_clr} = 6'h00;
        {timer_match, conversion_done, watchdog_match, interval_overflow, serial_done} = 8'h00;
        avs_address = 5'h00;
        avs_writedata = 32'h0;
        pins = 4'h0;
        ack_delay = 4'h0;
        be = 4'hF;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 6; i++) rdchk(5'(4 * i), 8'h00);
        bus(1'b0, `PIC_OFF_STAT, 8'h00);
        chk(rd, 32'h0000FFFE);
        rdchk(5'h1C, 8'h00);
        bus(1'b1, `PIC_OFF_REQ_HI, 8'hFF);
        rdchk(`PIC_OFF_REQ_HI, 8'hFF);
        bus(1'b1, `PIC_OFF_REQ_LO, 8'hFF);
        rdchk(`PIC_OFF_REQ_LO, 8'hF0);
        bus(1'b1, `PIC_OFF_EN_HI, 8'hFF);
        bus(1'b1, `PIC_OFF_EN_LO, 8'hF0);
        chk(32'(irq_req), 32'h0);
        bus(1'b1, `PIC_OFF_CTRL, 8'h04);
        for (int i = 0; i < 12; i++) wait_acks(8'(i + 1), 16'hFFFA - 16'(2 * i));
        rdchk(`PIC_OFF_REQ_HI, 8'h00);
        rdchk(`PIC_OFF_REQ_LO, 8'h00);
        bus(1'b1, `PIC_OFF_EN_HI, 8'h00);
        bus(1'b1, `PIC_OFF_EN_LO, 8'h00);
        ev(8'hFF);
        rdchk(`PIC_OFF_REQ_HI, 8'h33);
        rdchk(`PIC_OFF_REQ_LO, 8'hF0);
        bus(1'b1, `PIC_OFF_REQ_HI, 8'h00);
        bus(1'b1, `PIC_OFF_REQ_LO, 8'h40);
        bus(1'b1, `PIC_OFF_CTRL, 8'h05);
        rdchk(`PIC_OFF_CTRL, 8'h05);
        bus(1'b1, `PIC_OFF_EN_LO, 8'h40);
        repeat (5) @(negedge clk);
        chk(32'(irq_req), 32'h0);
        bus(1'b1, `PIC_OFF_CTRL, 8'h04);
        wait_acks(8'd13, 16'hFFE8);
        repeat (16) @(posedge clk);
        core_ie_clr <= 1'b1;
        @(posedge clk);
        core_ie_clr <= 1'b0;
        ev(8'h20);
        chk(32'(master_enable), 32'h0);
        bus(1'b1, `PIC_OFF_EN_HI, 8'h10);
        repeat (6) @(negedge clk);
        chk(32'(irq_req), 32'h0);
        rdchk(`PIC_OFF_REQ_HI, 8'h10);
        bus(1'b1, `PIC_OFF_CTRL, 8'h04);
        wait_acks(8'd14, 16'hFFF4);
        @(posedge clk);
        be <= 4'hE;
        bus(1'b1, `PIC_OFF_EDGE, 8'hFF);
        be <= 4'hF;
        rdchk(`PIC_OFF_EDGE, 8'h00);
        for (int m = 0; m < 4; m++) begin
            bus(1'b1, `PIC_OFF_EDGE, {4{2'(m)}});
            rdchk(`PIC_OFF_EDGE, {4{2'(m)}});
            @(posedge clk);
            pins <= 4'hF;
            repeat (6) @(posedge clk);
            rdchk(`PIC_OFF_REQ_HI, m[1] ? 8'hCC : 8'h00);
            bus(1'b1, `PIC_OFF_REQ_HI, 8'h00);
            @(posedge clk);
            pins <= 4'h0;
            repeat (6) @(posedge clk);
            rdchk(`PIC_OFF_REQ_HI, m[0] ? 8'hCC : 8'h00);
            bus(1'b1, `PIC_OFF_REQ_HI, 8'h00);
        end
        bus(1'b1, `PIC_OFF_CTRL, 8'h00);
        bus(1'b1, `PIC_OFF_EN_HI, 8'h00);
        ack_delay <= 4'h4;
        @(posedge clk);
        software_break <= 1'b1;
        @(posedge clk);
        software_break <= 1'b0;
        wait_acks(8'd15, `PIC_VEC_BRK);
        give_verdict();
    end
endmodule : tb_prioritized_interrupt_controller
